/* rtl/dprs_ref_select.v */
// Digital PLL reference, role and network reference output selection
`timescale 1ns/1ns
`include "dprs_defs.vh"

// Contract
// - Network reference divided by 1, 193, 256
// - Two-bit field picks local reference source
// - Primary master drives A, monitors B
// - Secondary master drives B, monitors A
// - Slave drives neither clock pair
// - Preference bit zero prefers primary reference
// - Frequency codes: 8k, 1.544M, 2.048M, bus
// - Primary frequency bus code forces A clock
// - Secondary frequency bus code forces B clock
// - Active A-clock primary aligns to A frame
// - Active B-clock secondary aligns to B frame
// - External mode takes failure from loss inputs
// - MTIE reset aligns to nearest reference edge
module dprs_ref_select
(
    // Clock and reset
    input  wire        clk_i,
    input  wire        srst_i,
    // Register port
    input  wire [3:0]  addr_i,
    input  wire [15:0] wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [15:0] rdata_o,
    // Reference inputs
    input  wire [3:0]  local_ref_in_i,
    input  wire [1:0]  backplane_ref_in_i,
    input  wire        pll_clk_i,
    // Backplane clock pairs and frames
    input  wire        bus_clock_side_a_i,
    output reg         bus_clock_side_a_o,
    output wire        bus_clock_side_a_oe_o,
    input  wire        bus_clock_side_b_i,
    output reg         bus_clock_side_b_o,
    output wire        bus_clock_side_b_oe_o,
    input  wire        frame_side_a_i,
    input  wire        frame_side_b_i,
    // Failure indications
    input  wire        primary_loss_in_i,
    input  wire        secondary_loss_in_i,
    input  wire        pri_monitor_fail_i,
    input  wire        sec_monitor_fail_i,
    // Towards the loop
    output reg         primary_reference_o,
    output reg         secondary_reference_o,
    output reg         active_is_secondary_o,
    output reg  [1:0]  frame_align_sel_o,
    output reg         frame_align_o,
    output reg         mtie_hold_o,
    output reg         nearest_edge_align_o,
    // Network reference
    output reg         network_reference_out_o
);

    // Synchroniser input indices
    localparam NSYNC   = 15;
    localparam I_LOC0  = 0;
    localparam I_BP1   = 4;
    localparam I_BP2   = 5;
    localparam I_PLL   = 6;
    localparam I_CA    = 7;
    localparam I_CB    = 8;
    localparam I_FA    = 9;
    localparam I_FB    = 10;
    localparam I_PLOS  = 11;
    localparam I_SLOS  = 12;
    localparam I_PMON  = 13;
    localparam I_SMON  = 14;

    wire [NSYNC-1:0] raw_w;
    reg  [NSYNC-1:0] s1_q;
    reg  [NSYNC-1:0] s2_q;
    reg  [NSYNC-1:0] s3_q;
    reg  [NSYNC-1:0] flt_q;

    reg  [15:0]      ref_cfg_q;
    reg  [15:0]      op_mode2_q;

    reg              pri_sel_d;
    reg              sec_sel_d;
    reg              nsrc_d;
    reg              nsrc_last_q;
    reg              act_last_q;
    reg  [8:0]       div_cnt_q;
    reg  [8:0]       ratio_d;
    reg  [1:0]       role_d;
    reg              pri_fail_d;
    reg              sec_fail_d;
    reg              act_sec_d;
    reg              cfg_err_d;

    wire [1:0]       sec_freq_w;
    wire [1:0]       pri_freq_w;
    wire [3:0]       sec_src_w;
    wire [3:0]       pri_src_w;
    wire [1:0]       fdm_w;
    wire [1:0]       div_w;
    wire [1:0]       nsrc_sel_w;
    wire             a_drive_w;
    wire             b_drive_w;
    wire             pref_sec_w;
    wire             mtie_rst_w;
    wire             act_ref_w;

    assign raw_w = {sec_monitor_fail_i, pri_monitor_fail_i,
                    secondary_loss_in_i, primary_loss_in_i,
                    frame_side_b_i, frame_side_a_i,
                    bus_clock_side_b_i, bus_clock_side_a_i,
                    pll_clk_i, backplane_ref_in_i, local_ref_in_i};

    // Three-stage synchronisers; a change is taken once stages 2 and 3 agree
    genvar g;
    generate
        for (g = 0; g < NSYNC; g = g + 1)
        begin : g_sync
            always @(posedge clk_i)
            begin
                if (srst_i)
                begin
                    s1_q[g]  <= 1'b0;
                    s2_q[g]  <= 1'b0;
                    s3_q[g]  <= 1'b0;
                    flt_q[g] <= 1'b0;
                end
                else
                begin
                    s1_q[g] <= raw_w[g];
                    s2_q[g] <= s1_q[g];
                    s3_q[g] <= s2_q[g];
                    if (s2_q[g] == s3_q[g])
                        flt_q[g] <= s3_q[g];
                end
            end
        end
    endgenerate

    // Field extraction
    assign b_drive_w  = ref_cfg_q[`DPRS_B_DRIVE_BIT];
    assign a_drive_w  = ref_cfg_q[`DPRS_A_DRIVE_BIT];
    assign pref_sec_w = ref_cfg_q[`DPRS_PREF_BIT];
    assign sec_freq_w = ref_cfg_q[`DPRS_SEC_FREQ_HI:`DPRS_SEC_FREQ_LO];
    assign pri_freq_w = ref_cfg_q[`DPRS_PRI_FREQ_HI:`DPRS_PRI_FREQ_LO];
    assign sec_src_w  = ref_cfg_q[`DPRS_SEC_SRC_HI:`DPRS_SEC_SRC_LO];
    assign pri_src_w  = ref_cfg_q[`DPRS_PRI_SRC_HI:`DPRS_PRI_SRC_LO];
    assign mtie_rst_w = op_mode2_q[`DPRS_MTIE_RST_BIT];
    assign fdm_w      = op_mode2_q[`DPRS_FDM_HI:`DPRS_FDM_LO];
    assign div_w      = op_mode2_q[`DPRS_DIV_HI:`DPRS_DIV_LO];
    assign nsrc_sel_w = op_mode2_q[`DPRS_NSRC_HI:`DPRS_NSRC_LO];

    // Bus clock pair drivers follow the role bits directly
    assign bus_clock_side_a_oe_o = a_drive_w;
    assign bus_clock_side_b_oe_o = b_drive_w;

    // Register writes; reserved bits are masked off
    always @(posedge clk_i)
    begin
        if (srst_i)
        begin
            ref_cfg_q  <= `DPRS_REF_CFG_RST;
            op_mode2_q <= `DPRS_OP_MODE2_RST;
        end
        else if (wr_i)
        begin
            if (addr_i == `DPRS_ADDR_REF_CFG)
                ref_cfg_q <= wdata_i & `DPRS_REF_CFG_MASK;
            if (addr_i == `DPRS_ADDR_OP_MODE2)
                op_mode2_q <= wdata_i & `DPRS_OP_MODE2_MASK;
        end
    end

    // Source decode for primary, secondary and network reference
    always @*
    begin
        // Unused selection codes give a quiet low reference
        case (pri_src_w)
            `DPRS_SRC_BP1:  pri_sel_d = flt_q[I_BP1];
            `DPRS_SRC_BP2:  pri_sel_d = flt_q[I_BP2];
            `DPRS_SRC_LOC0: pri_sel_d = flt_q[I_LOC0];
            `DPRS_SRC_LOC1: pri_sel_d = flt_q[I_LOC0+1];
            `DPRS_SRC_LOC2: pri_sel_d = flt_q[I_LOC0+2];
            `DPRS_SRC_LOC3: pri_sel_d = flt_q[I_LOC0+3];
            default:        pri_sel_d = 1'b0;
        endcase
        if (pri_freq_w == `DPRS_FREQ_BUS)
            pri_sel_d = flt_q[I_CA];
        case (sec_src_w)
            `DPRS_SRC_BP1:  sec_sel_d = flt_q[I_BP1];
            `DPRS_SRC_BP2:  sec_sel_d = flt_q[I_BP2];
            `DPRS_SRC_LOC0: sec_sel_d = flt_q[I_LOC0];
            `DPRS_SRC_LOC1: sec_sel_d = flt_q[I_LOC0+1];
            `DPRS_SRC_LOC2: sec_sel_d = flt_q[I_LOC0+2];
            `DPRS_SRC_LOC3: sec_sel_d = flt_q[I_LOC0+3];
            default:        sec_sel_d = 1'b0;
        endcase
        if (sec_freq_w == `DPRS_FREQ_BUS)
            sec_sel_d = flt_q[I_CB];
        nsrc_d = flt_q[I_LOC0 + nsrc_sel_w];
    end

    // Role decode, failure source and active reference choice
    always @*
    begin
        case ({b_drive_w, a_drive_w})
            2'h1:    role_d = `DPRS_ROLE_PRI_MASTER;
            2'h2:    role_d = `DPRS_ROLE_SEC_MASTER;
            2'h0:    role_d = `DPRS_ROLE_SLAVE;
            default: role_d = `DPRS_ROLE_INVALID;
        endcase
        if (fdm_w == `DPRS_FDM_EXT)
        begin
            pri_fail_d = flt_q[I_PLOS];
            sec_fail_d = flt_q[I_SLOS];
        end
        else
        begin
            pri_fail_d = flt_q[I_PMON];
            sec_fail_d = flt_q[I_SMON];
        end
        // Forced modes fix the choice; otherwise the preferred reference is kept unless it fails and the other is sound
        case (fdm_w)
            `DPRS_FDM_FPRI: act_sec_d = 1'b0;
            `DPRS_FDM_FSEC: act_sec_d = 1'b1;
            default:
                if (pref_sec_w)
                    act_sec_d = ~(sec_fail_d & ~pri_fail_d);
                else
                    act_sec_d = pri_fail_d & ~sec_fail_d;
        endcase
        // Flags the software-side role limits when they are broken
        cfg_err_d = ((role_d == `DPRS_ROLE_SLAVE) & ~mtie_rst_w)
                  | ((role_d == `DPRS_ROLE_PRI_MASTER)
                     & (fdm_w != `DPRS_FDM_AUTO))
                  | ((role_d != `DPRS_ROLE_PRI_MASTER)
                     & fdm_w[1])
                  | (role_d == `DPRS_ROLE_INVALID);
        // Divider ratio; the frequency codes act only through the bus code
        ratio_d = (div_w == `DPRS_DIV_193) ? `DPRS_RATIO_193
                                           : `DPRS_RATIO_256;
    end

    assign act_ref_w = act_sec_d ? sec_sel_d : pri_sel_d;

    // Loop-facing outputs and frame alignment choice
    always @(posedge clk_i)
    begin
        if (srst_i)
        begin
            primary_reference_o   <= 1'b0;
            secondary_reference_o <= 1'b0;
            active_is_secondary_o <= 1'b0;
            frame_align_sel_o     <= `DPRS_FRM_LOCAL;
            frame_align_o         <= 1'b0;
            mtie_hold_o           <= 1'b0;
            nearest_edge_align_o  <= 1'b0;
            act_last_q            <= 1'b0;
            bus_clock_side_a_o    <= 1'b0;
            bus_clock_side_b_o    <= 1'b0;
        end
        else
        begin
            primary_reference_o   <= pri_sel_d;
            secondary_reference_o <= sec_sel_d;
            active_is_secondary_o <= act_sec_d;
            act_last_q            <= act_ref_w;
            // Bus code on the active side ties frames to that side
            if (!act_sec_d && pri_freq_w == `DPRS_FREQ_BUS)
            begin
                frame_align_sel_o <= `DPRS_FRM_SIDE_A;
                frame_align_o     <= flt_q[I_FA];
            end
            else if (act_sec_d && sec_freq_w == `DPRS_FREQ_BUS)
            begin
                frame_align_sel_o <= `DPRS_FRM_SIDE_B;
                frame_align_o     <= flt_q[I_FB];
            end
            else
            begin
                frame_align_sel_o <= `DPRS_FRM_LOCAL;
                frame_align_o     <= 1'b0;
            end
            // Held MTIE snaps the loop to each reference rising edge
            mtie_hold_o          <= mtie_rst_w;
            nearest_edge_align_o <= mtie_rst_w & act_ref_w
                                    & ~act_last_q;
            // Sampled loop clock; only a stand-in at this sample rate
            bus_clock_side_a_o <= flt_q[I_PLL] & a_drive_w;
            bus_clock_side_b_o <= flt_q[I_PLL] & b_drive_w;
        end
    end

    // Network reference divider, counted on rising source edges
    always @(posedge clk_i)
    begin
        if (srst_i)
        begin
            nsrc_last_q             <= 1'b0;
            div_cnt_q               <= 9'h000;
            network_reference_out_o <= 1'b0;
        end
        else
        begin
            nsrc_last_q <= nsrc_d;
            if (nsrc_d & ~nsrc_last_q)
            begin
                if (div_cnt_q >= ratio_d - 9'h001)
                    div_cnt_q <= 9'h000;
                else
                    div_cnt_q <= div_cnt_q + 9'h001;
            end
            // Reserved code holds the output low rather than guess
            case (div_w)
                `DPRS_DIV_NONE:
                    network_reference_out_o <= nsrc_d;
                `DPRS_DIV_193, `DPRS_DIV_256:
                    network_reference_out_o <=
                        (div_cnt_q < {1'b0, ratio_d[8:1]});
                default:
                    network_reference_out_o <= 1'b0;
            endcase
        end
    end

    // Register read, data one cycle after the strobe
    always @(posedge clk_i)
    begin
        if (srst_i)
            rdata_o <= 16'h0000;
        else if (rd_i)
        begin
            case (addr_i)
                `DPRS_ADDR_REF_CFG:  rdata_o <= ref_cfg_q;
                `DPRS_ADDR_OP_MODE2: rdata_o <= op_mode2_q;
                `DPRS_ADDR_STATUS:
                    rdata_o <= {10'h000, cfg_err_d, sec_fail_d,
                                pri_fail_d, act_sec_d, role_d};
                default:             rdata_o <= 16'h0000;
            endcase
        end
        else
            rdata_o <= 16'h0000;
    end

endmodule // dprs_ref_select

/* rtl/dprs_defs.vh */
// Register offsets, field positions and codes of the reference selector
`ifndef DPRS_DEFS_VH
`define DPRS_DEFS_VH

// Register offsets (word index on the register port)
`define DPRS_ADDR_REF_CFG     4'h0
`define DPRS_ADDR_OP_MODE2    4'h1
`define DPRS_ADDR_STATUS      4'h2

// Reset values
`define DPRS_REF_CFG_RST      16'h0000
`define DPRS_OP_MODE2_RST     16'h0000

// Reference configuration fields
`define DPRS_B_DRIVE_BIT      14
`define DPRS_A_DRIVE_BIT      13
`define DPRS_PREF_BIT         12
`define DPRS_SEC_FREQ_HI      11
`define DPRS_SEC_FREQ_LO      10
`define DPRS_PRI_FREQ_HI      9
`define DPRS_PRI_FREQ_LO      8
`define DPRS_SEC_SRC_HI       7
`define DPRS_SEC_SRC_LO       4
`define DPRS_PRI_SRC_HI       3
`define DPRS_PRI_SRC_LO       0

// Operation mode two fields
`define DPRS_MTIE_RST_BIT     10
`define DPRS_FDM_HI           9
`define DPRS_FDM_LO           8
`define DPRS_DIV_HI           4
`define DPRS_DIV_LO           3
`define DPRS_NSRC_HI          1
`define DPRS_NSRC_LO          0

// Writable bit masks (reserved bits read zero)
`define DPRS_REF_CFG_MASK     16'h7FFF
`define DPRS_OP_MODE2_MASK    16'h071B

// Frequency codes
`define DPRS_FREQ_8K          2'h0
`define DPRS_FREQ_1544K       2'h1
`define DPRS_FREQ_2048K       2'h2
`define DPRS_FREQ_BUS         2'h3

// Source selection codes
`define DPRS_SRC_BP1          4'h0
`define DPRS_SRC_BP2          4'h1
`define DPRS_SRC_LOC0         4'h8
`define DPRS_SRC_LOC1         4'h9
`define DPRS_SRC_LOC2         4'hA
`define DPRS_SRC_LOC3         4'hB

// Divider codes and ratios
`define DPRS_DIV_NONE         2'h0
`define DPRS_DIV_193          2'h1
`define DPRS_DIV_256          2'h2
`define DPRS_RATIO_193        9'h0C1
`define DPRS_RATIO_256        9'h100

// Failure detect codes
`define DPRS_FDM_AUTO         2'h0
`define DPRS_FDM_EXT          2'h1
`define DPRS_FDM_FPRI         2'h2
`define DPRS_FDM_FSEC         2'h3

// Clocking roles, as reported in status
`define DPRS_ROLE_SLAVE       2'h0
`define DPRS_ROLE_PRI_MASTER  2'h1
`define DPRS_ROLE_SEC_MASTER  2'h2
`define DPRS_ROLE_INVALID     2'h3

// Frame alignment source codes
`define DPRS_FRM_LOCAL        2'h0
`define DPRS_FRM_SIDE_A       2'h1
`define DPRS_FRM_SIDE_B       2'h2

`endif

/* sim/dprs_monitor.sv */
// Port-level checker of the reference selector
`timescale 1ns/1ns
module dprs_mon
(
    // Clock, reset, register port
    input wire logic        clk_i,
    input wire logic        srst_i,
    input wire logic [3:0]  addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [15:0] rdata_o,
    // Watched outputs
    input wire logic        bus_clock_side_a_oe_o,
    input wire logic        bus_clock_side_b_oe_o,
    input wire logic [1:0]  frame_align_sel_o,
    input wire logic        frame_align_o,
    input wire logic        mtie_hold_o,
    input wire logic        nearest_edge_align_o,
    input wire logic        network_reference_out_o
);
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (srst_i);
    logic [1:0] div_q;
    logic [3:0] age_q;
    // Divider code shadow; age lets the output settle after a write
    always @(posedge clk_i)
    begin
        if (srst_i || (wr_i && addr_i == 4'h1))
            age_q <= 4'h0;
        else if (age_q != 4'hF)
            age_q <= age_q + 4'h1;
        if (srst_i || (wr_i && addr_i == 4'h1))
            div_q <= srst_i ? 2'h0 : wdata_i[4:3];
    end
    sequence s_cfg_wr;
        wr_i && addr_i == 4'h0;
    endsequence
    sequence s_rd(logic [3:0] a);
        rd_i && addr_i == a;
    endsequence
    chk_a_drive: assert property (
        s_cfg_wr |=> bus_clock_side_a_oe_o == $past(wdata_i[13]))
        else $error("A clock enable differs from written bit");
    chk_b_drive: assert property (
        s_cfg_wr |=> bus_clock_side_b_oe_o == $past(wdata_i[14]))
        else $error("B clock enable differs from written bit");
    chk_cfg_read: assert property (
        s_rd(4'h0) |=> rdata_o[15:13] == {1'b0,
        $past(bus_clock_side_b_oe_o), $past(bus_clock_side_a_oe_o)})
        else $error("Enable bits read back wrong");
    chk_role_read: assert property (
        s_rd(4'h2) |=> rdata_o[1:0] ==
        {$past(bus_clock_side_b_oe_o), $past(bus_clock_side_a_oe_o)})
        else $error("Role in status wrong");
    chk_rd_idle: assert property (
        !$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("Read data outside its cycle");
    chk_div_hold: assert property (
        div_q == 2'h3 && age_q == 4'hF |-> !network_reference_out_o)
        else $error("Reserved divider code let output rise");
    chk_frm_local: assert property (
        frame_align_sel_o != 2'h3 &&
        (frame_align_sel_o != 2'h0 || !frame_align_o))
        else $error("Frame alignment select or level wrong");
    chk_edge_pulse: assert property (
        nearest_edge_align_o |=> !nearest_edge_align_o)
        else $error("Edge align pulse longer than one cycle");
    chk_edge_held: assert property (
        nearest_edge_align_o |-> mtie_hold_o || $past(mtie_hold_o))
        else $error("Edge align pulse without MTIE hold");
endmodule // dprs_mon

bind dprs_ref_select dprs_mon u_mon
(
    .clk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .bus_clock_side_a_oe_o, .bus_clock_side_b_oe_o, .frame_align_sel_o,
    .frame_align_o, .mtie_hold_o, .nearest_edge_align_o,
    .network_reference_out_o
);

/* sim/dprs_far_side.sv */
// Far side: local and backplane references, bus clocks, frames
`timescale 1ns/1ns
module dprs_far_side
(
    // Device drive of the bus clock pins
    input  wire logic       a_oe_i,
    input  wire logic       a_drv_i,
    input  wire logic       b_oe_i,
    input  wire logic       b_drv_i,
    // Levels towards the device
    output wire logic [3:0] local_ref_o,
    output wire logic [1:0] bp_ref_o,
    output wire logic       side_a_o,
    output wire logic       side_b_o,
    output wire logic       frame_a_o,
    output wire logic       frame_b_o,
    output wire logic       pll_clk_o
);
    logic [7:0] tick_q = 8'h00;
    logic       ca_q = 1'b0;
    logic       cb_q = 1'b0;
    logic       pll_q = 1'b0;
    // Link rate 200 ns, offset so no edge meets the system clock
    initial
    begin
        #13;
        forever #200 tick_q = tick_q + 8'h01;
    end
    // Other masters' bus clocks, slowed so a 20 MHz sampler sees them
    always #300 ca_q = ~ca_q;
    always #500 cb_q = ~cb_q;
    always #150 pll_q = ~pll_q;
    // A pin carries the device's level only while it drives it
    assign side_a_o = a_oe_i ? a_drv_i : ca_q;
    assign side_b_o = b_oe_i ? b_drv_i : cb_q;
    assign local_ref_o = tick_q[3:0];
    assign bp_ref_o = tick_q[5:4];
    assign frame_a_o = &tick_q[3:0];
    assign frame_b_o = &tick_q[4:0];
    assign pll_clk_o = pll_q;
endmodule // dprs_far_side

/* sim/tb_top.sv */
// Self-checking bench of the reference selector
`timescale 1ns/1ns
`include "dprs_defs.vh"
module tb_top;
    // Driven inputs
    logic        clk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic [3:0]  addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        primary_loss_in_i = 1'b0;
    logic        secondary_loss_in_i = 1'b0;
    logic        pri_monitor_fail_i = 1'b0;
    logic        sec_monitor_fail_i = 1'b0;
    // Design outputs and far-side levels
    wire [15:0] rdata_o;
    wire [3:0]  local_ref_in_i;
    wire [1:0]  backplane_ref_in_i, frame_align_sel_o;
    wire        pll_clk_i, frame_side_a_i, frame_side_b_i;
    wire        bus_clock_side_a_i, bus_clock_side_a_o, bus_clock_side_a_oe_o;
    wire        bus_clock_side_b_i, bus_clock_side_b_o, bus_clock_side_b_oe_o;
    wire        primary_reference_o, secondary_reference_o, frame_align_o;
    wire        active_is_secondary_o, mtie_hold_o, nearest_edge_align_o;
    wire        network_reference_out_o;
    wire [4:0]  obs = {bus_clock_side_b_o, bus_clock_side_a_o,
                       secondary_reference_o, primary_reference_o,
                       network_reference_out_o};
    // Register model and role tables
    logic [15:0] mdl [0:1] = '{16'h0000, 16'h0000};
    logic [15:0] r_cfg [0:2] = '{16'h2080, 16'h4390, 16'h0FAB};
    logic [15:0] r_m2 [0:2] = '{16'h0000, 16'h0100, 16'h0400};
    logic [15:0] r_pp [0:2] = '{16'h0080, 16'h000C, 16'h000C};
    logic [15:0] r_sp [0:2] = '{16'h0008, 16'h0010, 16'h0014};
    logic [15:0] r_fs [0:2] = '{16'h0000, 16'h0001, 16'h0001};
    logic [15:0] got;
    logic [3:0]  ra;
    int          bad_count = 0, n_checks = 0, cyc = 0, seed = 70, j, k;

    dprs_ref_select u_dut
    (
        .clk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .local_ref_in_i, .backplane_ref_in_i, .pll_clk_i,
        .bus_clock_side_a_i, .bus_clock_side_a_o, .bus_clock_side_a_oe_o,
        .bus_clock_side_b_i, .bus_clock_side_b_o, .bus_clock_side_b_oe_o,
        .frame_side_a_i, .frame_side_b_i, .primary_loss_in_i,
        .secondary_loss_in_i, .pri_monitor_fail_i, .sec_monitor_fail_i,
        .primary_reference_o, .secondary_reference_o, .active_is_secondary_o,
        .frame_align_sel_o, .frame_align_o, .mtie_hold_o,
        .nearest_edge_align_o, .network_reference_out_o
    );
    dprs_far_side u_far
    (
        .a_oe_i(bus_clock_side_a_oe_o), .a_drv_i(bus_clock_side_a_o),
        .b_oe_i(bus_clock_side_b_oe_o), .b_drv_i(bus_clock_side_b_o),
        .local_ref_o(local_ref_in_i), .bp_ref_o(backplane_ref_in_i),
        .side_a_o(bus_clock_side_a_i), .side_b_o(bus_clock_side_b_i),
        .frame_a_o(frame_side_a_i), .frame_b_o(frame_side_b_i),
        .pll_clk_o(pll_clk_i)
    );

    initial forever #25 clk_i = ~clk_i;

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
        if (a == 4'h0)
            mdl[0] = d & `DPRS_REF_CFG_MASK;
        if (a == 4'h1)
            mdl[1] = d & `DPRS_OP_MODE2_MASK;
    endtask
    // Status holds only the role here; bit 5 is masked in by callers
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] m);
        logic [15:0] e;
        e = a < 4'h2 ? mdl[a[0]] : 16'h0000;
        if (a == 4'h2)
            e = {14'h0, mdl[0][14:13]};
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        chk(rdata_o & m, e & m);
    endtask
    // Cycles between two rises; settles first since inputs lag 5 edges
    task automatic meas(input int i, output logic [15:0] n);
        int c, r, t0;
        logic p;
        r = 0;
        t0 = 0;
        n = 16'h0000;
        p = 1'b1;
        repeat (10) @(posedge clk_i);
        for (c = 0; c < 5000 && r < 2; c++)
        begin
            @(negedge clk_i);
            if (obs[i] && !p)
            begin
                if (r == 1)
                    n = 16'(c - t0);
                t0 = c;
                r++;
            end
            p = obs[i];
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Hang guard, well above the longest divider measurement
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            bad_count++;
            complete_run();
        end
    end

    initial
    begin
        repeat (12) @(posedge clk_i);
        srst_i <= 1'b0;
        rd_chk(4'h0, 16'hFFFF);
        rd_chk(4'h1, 16'hFFFF);
        // Legal settings of the three clocking roles
        for (j = 0; j < 3; j++)
        begin
            wr_reg(4'h0, r_cfg[j]);
            wr_reg(4'h1, r_m2[j]);
            @(negedge clk_i);
            chk({14'h0, bus_clock_side_b_oe_o, bus_clock_side_a_oe_o},
                {14'h0, r_cfg[j][14:13]});
            rd_chk(4'h0, 16'hFFFF);
            rd_chk(4'h2, 16'h0023);
            meas(1, got);
            chk(got, r_pp[j]);
            meas(2, got);
            chk(got, r_sp[j]);
            chk({14'h0, frame_align_sel_o}, r_fs[j]);
            // Loop clock (6 cycles) on a pin only while that side drives
            meas(j == 1 ? 4 : 3, got);
            chk(got, j == 2 ? 16'h0000 : 16'h0006);
            k = 0;
            repeat (100)
            begin
                @(negedge clk_i);
                k += nearest_edge_align_o;
            end
            chk({15'h0, k != 0}, {15'h0, r_m2[j][10]});
        end
        // Every primary frequency code, local input 0 selected
        for (j = 0; j < 4; j++)
        begin
            wr_reg(4'h0, 16'h0008 | 16'(j << 8));
            meas(1, got);
            chk(got, j == 3 ? 16'h000C : 16'h0008);
        end
        // Failure source per detect mode, slave on both bus clocks
        wr_reg(4'h0, 16'h0F00);
        for (j = 0; j < 4; j++)
        begin
            @(posedge clk_i);
            pri_monitor_fail_i <= !j[0];
            primary_loss_in_i <= j[0];
            wr_reg(4'h1, j[1] ? 16'h0500 : 16'h0400);
            repeat (8) @(posedge clk_i);
            @(negedge clk_i);
            k = j[1] ? j[0] : !j[0];
            chk({15'h0, active_is_secondary_o}, 16'(k));
            chk({14'h0, frame_align_sel_o}, 16'(k + 1));
            chk({15'h0, mtie_hold_o}, 16'h0001);
        end
        @(posedge clk_i);
        pri_monitor_fail_i <= 1'b0;
        primary_loss_in_i <= 1'b0;
        // Network source codes, then each divider code
        for (j = 0; j < 7; j++)
        begin
            wr_reg(4'h1, j < 4 ? 16'(j) : 16'((j - 3) << 3));
            meas(0, got);
            chk(got, j < 4 ? 16'(8 << j) : j == 4 ? 16'h0608 :
                j == 5 ? 16'h0800 : 16'h0000);
        end
        // Random writes, status and unmapped places included
        repeat (8)
        begin
            ra = 4'($random(seed) & 3);
            wr_reg(ra, 16'($random(seed)));
            rd_chk(ra, ra == 4'h2 ? 16'h0003 : 16'hFFFF);
        end
        wr_reg(4'h9, 16'hFFFF);
        rd_chk(4'h9, 16'hFFFF);
        complete_run();
    end
endmodule // tb_top
